// ==== hw/module_mgmt_pkg.sv ====
// constants and types for the module management timing block
package module_mgmt_pkg;

  // clock and flag layout
  localparam int CLOCK_PERIOD_NS = 10;
  localparam int NUM_FLAGS       = 8;
  localparam int RX_LOS_FLAG     = 0;
  localparam int TX_FAULT_FLAG   = 1;

  // reset pin pulse: least time, rounded up
  localparam int RESET_PULSE_US     = 2;
  localparam int RESET_PULSE_CYCLES = (RESET_PULSE_US * 1000 + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int RESET_CNT_W        = 8;

  // initialisation: longest time, rounded down
  localparam longint INIT_TIME_MS    = 2000;
  localparam longint INIT_CYCLES_DEF = (INIT_TIME_MS * 64'd1000000) / CLOCK_PERIOD_NS;
  localparam int     INIT_CNT_W      = 28;

  // values after reset
  localparam logic [NUM_FLAGS-1:0] MASK_RESET           = 8'h00;
  localparam logic [NUM_FLAGS-1:0] FLAGS_RESET          = 8'h00;
  localparam logic                 PDOWN_RESET          = 1'b0;
  localparam logic                 DATA_NOT_READY_RESET = 1'b1;

  // control written by a finished write transaction
  typedef struct packed {
    logic [NUM_FLAGS-1:0] mask;
    logic                 pdown;
  } link_write_t;

  // flags read by a finished read transaction
  typedef struct packed {
    logic                 status;
    logic [NUM_FLAGS-1:0] flags;
  } link_read_t;

  // initialisation sequence, gray coded
  typedef enum logic [1:0] {
    ST_HOLD  = 2'b00,
    ST_INIT  = 2'b01,
    ST_READY = 2'b11
  } init_state_t;

endpackage : module_mgmt_pkg

// ==== hw/module_mgmt_status_timing.sv ====
// control and status timing of the module management interface
//
// Summary of operation
// - fully functional within 2000 ms of power-on, insertion or reset release
// - reset pin low longer than 2 us is a reset; host holds it that long
// - serial bus responds within 2000 ms of power-on
// - within 2000 ms clear data-not-ready and assert interrupt request
// - fully functional only once interrupt raised by data-not-ready clearing
// - low-power pin high enters lower power within 100 us
// - interrupt request driven low within 200 ms of a triggering condition
// - reading a flag clears it; interrupt released within 500 us
// - release time counted from falling link clock after read stop bit
// - receive signal loss sets its flag and interrupt within 100 ms
// - transmit fault sets its flag and interrupt within 200 ms
// - any other condition sets its flag and interrupt within 200 ms
// - setting a mask bit inhibits that flag's interrupt within 100 ms
// - clearing a mask bit resumes that flag's interrupt within 100 ms
// - serial bus responds within 100 us of select going low
// - serial bus stops responding within 100 us of select going high
// - setting power-down bit enters lower power within 100 ms
// - clearing power-down bit returns to full function within 300 ms
// - mask and power-down timing counted from falling link clock after write stop
`timescale 1ns/1ps

module module_mgmt_status_timing
  import module_mgmt_pkg::*;
#(
  parameter int     FLAG_COUNT  = NUM_FLAGS,
  parameter longint INIT_CYCLES = INIT_CYCLES_DEF
) (
  // system
  input  wire logic                  clock,
  input  wire logic                  rst,
  // module pins
  input  wire logic                  module_reset_n,
  input  wire logic                  module_select_n,
  input  wire logic                  low_power_request,
  output      logic                  interrupt_request_n,
  // flag conditions
  input  wire logic [FLAG_COUNT-1:0] flag_condition,
  // serial link side
  input  wire logic                  link_clock,
  input  wire logic                  link_write_done,
  input  wire link_write_t           link_write,
  input  wire logic                  link_read_done,
  input  wire link_read_t            link_read,
  // status
  output      logic                  serial_enable,
  output      logic                  data_not_ready,
  output      logic                  fully_functional,
  output      logic                  low_power_active,
  output      logic [FLAG_COUNT-1:0] flags,
  output      logic [FLAG_COUNT-1:0] mask
);

  // link domain: captured on falling link clock after stop
  link_write_t link_write_reg;
  link_read_t  link_read_reg;
  logic        link_write_toggle_reg;
  logic        link_read_toggle_reg;

  always_ff @(negedge link_clock or posedge rst) begin
    if (rst) begin
      link_write_reg        <= '{mask: MASK_RESET, pdown: PDOWN_RESET};
      link_write_toggle_reg <= 1'b0;
    end else if (link_write_done) begin
      link_write_reg        <= link_write;
      link_write_toggle_reg <= ~link_write_toggle_reg;
    end
  end

  always_ff @(negedge link_clock or posedge rst) begin
    if (rst) begin
      link_read_reg        <= '{status: 1'b0, flags: FLAGS_RESET};
      link_read_toggle_reg <= 1'b0;
    end else if (link_read_done) begin
      link_read_reg        <= link_read;
      link_read_toggle_reg <= ~link_read_toggle_reg;
    end
  end

  // pin and toggle synchronisers
  logic [2:0]            write_sync_reg;
  logic [2:0]            read_sync_reg;
  logic [1:0]            reset_pin_sync_reg;
  logic [1:0]            select_sync_reg;
  logic [1:0]            lp_sync_reg;
  logic [FLAG_COUNT-1:0] cond_meta_reg;
  logic [FLAG_COUNT-1:0] cond_sync_reg;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      write_sync_reg     <= 3'h0;
      read_sync_reg      <= 3'h0;
      reset_pin_sync_reg <= 2'h0;
      select_sync_reg    <= 2'h3;
      lp_sync_reg        <= 2'h0;
      cond_meta_reg      <= '0;
      cond_sync_reg      <= '0;
    end else begin
      write_sync_reg     <= {write_sync_reg[1:0], link_write_toggle_reg};
      read_sync_reg      <= {read_sync_reg[1:0], link_read_toggle_reg};
      reset_pin_sync_reg <= {reset_pin_sync_reg[0], module_reset_n};
      select_sync_reg    <= {select_sync_reg[0], module_select_n};
      lp_sync_reg        <= {lp_sync_reg[0], low_power_request};
      cond_meta_reg      <= flag_condition;
      cond_sync_reg      <= cond_meta_reg;
    end
  end

  logic write_event;
  logic read_event;
  logic reset_pin_n;
  logic select_n;
  logic lp_pin;

  assign write_event = write_sync_reg[2] ^ write_sync_reg[1];
  assign read_event  = read_sync_reg[2] ^ read_sync_reg[1];
  assign reset_pin_n = reset_pin_sync_reg[1];
  assign select_n    = select_sync_reg[1];
  assign lp_pin      = lp_sync_reg[1];

  // reset pin pulse filter
  logic [RESET_CNT_W-1:0] reset_count_reg;
  logic                   pin_reset_reg;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      reset_count_reg <= '0;
      pin_reset_reg   <= 1'b0;
    end else if (reset_pin_n) begin
      reset_count_reg <= '0;
      pin_reset_reg   <= 1'b0;
    end else if (reset_count_reg == RESET_CNT_W'(RESET_PULSE_CYCLES)) begin
      pin_reset_reg   <= 1'b1;
    end else begin
      reset_count_reg <= reset_count_reg + 1'b1;
    end
  end

  // initialisation sequence
  init_state_t           state_reg;
  init_state_t           state_next;
  logic [INIT_CNT_W-1:0] init_count_reg;
  logic                  init_done;

  assign init_done = init_count_reg == INIT_CNT_W'(INIT_CYCLES - 1);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_HOLD: begin
        if (reset_pin_n) begin
          state_next = ST_INIT;
        end
      end
      ST_INIT: begin
        if (init_done) begin
          state_next = ST_READY;
        end
      end
      ST_READY: state_next = ST_READY;
      default:  state_next = ST_HOLD;
    endcase
    if (pin_reset_reg) begin
      state_next = ST_HOLD;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg <= ST_HOLD;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      init_count_reg <= '0;
    end else if (state_reg != ST_INIT) begin
      init_count_reg <= '0;
    end else if (!init_done) begin
      init_count_reg <= init_count_reg + 1'b1;
    end
  end

  // data not ready and its interrupt source
  logic ready_rise;
  logic status_pending_reg;

  assign ready_rise = state_reg == ST_INIT && state_next == ST_READY;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      data_not_ready     <= DATA_NOT_READY_RESET;
      status_pending_reg <= 1'b0;
    end else if (state_next != ST_READY) begin
      data_not_ready     <= DATA_NOT_READY_RESET;
      status_pending_reg <= 1'b0;
    end else if (ready_rise) begin
      data_not_ready     <= 1'b0;
      status_pending_reg <= 1'b1;
    end else if (read_event && link_read_reg.status) begin
      status_pending_reg <= 1'b0;
    end
  end

  // latched flags, set wins over clear on read
  generate
    for (genvar i = 0; i < FLAG_COUNT; i++) begin : g_flag
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          flags[i] <= FLAGS_RESET[i];
        end else if (state_reg != ST_READY) begin
          flags[i] <= FLAGS_RESET[i];
        end else if (cond_sync_reg[i]) begin
          flags[i] <= 1'b1;
        end else if (read_event && link_read_reg.flags[i]) begin
          flags[i] <= 1'b0;
        end
      end
    end
  endgenerate

  // mask and power-down control from write transactions
  logic pdown_reg;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mask      <= MASK_RESET;
      pdown_reg <= PDOWN_RESET;
    end else if (state_reg != ST_READY) begin
      mask      <= MASK_RESET;
      pdown_reg <= PDOWN_RESET;
    end else if (write_event) begin
      mask      <= link_write_reg.mask;
      pdown_reg <= link_write_reg.pdown;
    end
  end

  // interrupt request pin
  logic irq_pending;

  assign irq_pending = |(flags & ~mask) | status_pending_reg;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      interrupt_request_n <= 1'b1;
    end else begin
      interrupt_request_n <= ~irq_pending;
    end
  end

  // power level, bus gating and full function
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      low_power_active <= 1'b0;
    end else begin
      low_power_active <= lp_pin | pdown_reg;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      serial_enable <= 1'b0;
    end else begin
      serial_enable <= state_reg == ST_READY && !select_n;
    end
  end

  // init interrupt seen once, kept through low power
  logic init_signalled_reg;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      init_signalled_reg <= 1'b0;
    end else if (state_reg != ST_READY) begin
      init_signalled_reg <= 1'b0;
    end else if (!interrupt_request_n && !data_not_ready) begin
      init_signalled_reg <= 1'b1;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      fully_functional <= 1'b0;
    end else if (state_reg != ST_READY || low_power_active) begin
      fully_functional <= 1'b0;
    end else if (init_signalled_reg || (!interrupt_request_n && !data_not_ready)) begin
      fully_functional <= 1'b1;
    end
  end

  // checks
  reset_filter_a: assert property (
    @(posedge clock) disable iff (rst)
    !reset_pin_n [*3] ##1 (!reset_pin_n && reset_count_reg == RESET_CNT_W'(RESET_PULSE_CYCLES))
    |=> pin_reset_reg ##1 state_reg == ST_HOLD)
    else $error("long reset pulse did not reset module");

  init_ready_a: assert property (
    @(posedge clock) disable iff (rst)
    ready_rise && !pin_reset_reg |=> !data_not_ready && status_pending_reg ##1 !interrupt_request_n)
    else $error("init end did not clear not-ready and raise interrupt");

  irq_assert_a: assert property (
    @(posedge clock) disable iff (rst)
    irq_pending |=> !interrupt_request_n)
    else $error("pending flag did not pull interrupt low");

  irq_release_a: assert property (
    @(posedge clock) disable iff (rst)
    !interrupt_request_n ##1 !irq_pending |=> interrupt_request_n)
    else $error("interrupt not released after flags cleared");

  flag_latch_a: assert property (
    @(posedge clock) disable iff (rst)
    state_reg == ST_READY && state_next == ST_READY && $rose(flags[RX_LOS_FLAG]) && !read_event
    |=> flags[RX_LOS_FLAG])
    else $error("receive loss flag dropped without a read");

  flag_set_a: assert property (
    @(posedge clock) disable iff (rst)
    state_reg == ST_READY && state_next == ST_READY && cond_sync_reg[TX_FAULT_FLAG]
    |=> flags[TX_FAULT_FLAG] ##1 (mask[TX_FAULT_FLAG] || !interrupt_request_n))
    else $error("transmit fault not latched or not signalled");

  mask_inhibit_a: assert property (
    @(posedge clock) disable iff (rst)
    (mask == flags) && flags != '0 && !status_pending_reg |=> interrupt_request_n)
    else $error("masked flags still drive interrupt");

  select_gate_a: assert property (
    @(posedge clock) disable iff (rst)
    select_n |=> !serial_enable)
    else $error("bus still enabled after deselect");

  low_power_a: assert property (
    @(posedge clock) disable iff (rst)
    (lp_pin || pdown_reg) |=> low_power_active ##1 !fully_functional)
    else $error("low power request not honoured");

  link_capture_a: assert property (
    @(negedge link_clock) disable iff (rst)
    link_write_done |=> link_write_reg == $past(link_write) && link_write_toggle_reg != $past(link_write_toggle_reg))
    else $error("write transaction not captured on falling link clock");

  select_enable_a: assert property (
    @(posedge clock) disable iff (rst)
    !select_n && state_reg == ST_READY |=> serial_enable)
    else $error("bus not enabled after select");

  flag_clear_a: assert property (
    @(posedge clock) disable iff (rst)
    read_event && link_read_reg.flags[RX_LOS_FLAG] && !cond_sync_reg[RX_LOS_FLAG] |=> !flags[RX_LOS_FLAG])
    else $error("read did not clear receive loss flag");

  status_clear_a: assert property (
    @(posedge clock) disable iff (rst)
    read_event && link_read_reg.status && !ready_rise |=> !status_pending_reg)
    else $error("read did not clear init interrupt source");

  mask_resume_a: assert property (
    @(posedge clock) disable iff (rst)
    $fell(mask[RX_LOS_FLAG]) && flags[RX_LOS_FLAG] |=> !interrupt_request_n)
    else $error("unmasked flag did not pull interrupt low");

  pdown_exit_a: assert property (
    @(posedge clock) disable iff (rst)
    $fell(pdown_reg) && !lp_pin && init_signalled_reg ##1 state_reg == ST_READY |=> fully_functional)
    else $error("power-down clear did not restore full function");

endmodule : module_mgmt_status_timing

// ==== testbench/host_link_model.sv ====
// host-side serial engine model driving the link side of the block
`timescale 1ns/1ps
module host_link_model
  import module_mgmt_pkg::*;
(
  // link side
  output logic        link_clock,
  output logic        link_write_done,
  output link_write_t link_write,
  output logic        link_read_done,
  output link_read_t  link_read
);
  initial begin
    link_clock      = 1'b0;
    link_write_done = 1'b0;
    link_write      = '0;
    link_read_done  = 1'b0;
    link_read       = '0;
  end

  // one frame, clock runs only inside it; slow adds idle link cycles before the stop
  task automatic transfer(input logic wr, input link_write_t w, input link_read_t r, input int slow);
    for (int i = 0; i < 4 + slow; i++) begin
      #6 link_clock = 1'b1;
      if (i == 1 + slow) begin
        link_write_done = wr;
        link_read_done  = !wr;
        link_write      = w;
        link_read       = r;
      end else if (i == 2 + slow) begin
        link_write_done = 1'b0;
        link_read_done  = 1'b0;
        link_write      = ~w;
        link_read       = ~r;
      end
      #6 link_clock = 1'b0;
    end
  endtask : transfer
endmodule : host_link_model

// ==== testbench/tb.sv ====
// self-checking bench for the module management timing block
`timescale 1ns/1ps
module tb;
  import module_mgmt_pkg::*;
  logic clock, rst, module_reset_n, module_select_n, low_power_request, interrupt_request_n;
  logic serial_enable, data_not_ready, fully_functional, low_power_active;
  logic link_clock, link_write_done, link_read_done;
  logic [7:0]  flag_condition, flags, mask;
  link_write_t link_write;
  link_read_t  link_read;
  int          errors, samples_checked;

  module_mgmt_status_timing #(.FLAG_COUNT(8), .INIT_CYCLES(50)) module_mgmt_status_timing_i (
    .clock(clock), .rst(rst), .module_reset_n(module_reset_n), .module_select_n(module_select_n),
    .low_power_request(low_power_request), .interrupt_request_n(interrupt_request_n),
    .flag_condition(flag_condition), .link_clock(link_clock), .link_write_done(link_write_done),
    .link_write(link_write), .link_read_done(link_read_done), .link_read(link_read),
    .serial_enable(serial_enable), .data_not_ready(data_not_ready), .fully_functional(fully_functional),
    .low_power_active(low_power_active), .flags(flags), .mask(mask));

  host_link_model host_link_model_i (.link_clock(link_clock), .link_write_done(link_write_done),
    .link_write(link_write), .link_read_done(link_read_done), .link_read(link_read));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask : cyc

  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : close_out

  task automatic wr(input logic [7:0] m, input logic p);
    host_link_model_i.transfer(1'b1, '{mask: m, pdown: p}, '0, 0);
    cyc(10);
    check(mask, m, "mask after write");
  endtask : wr

  task automatic rd(input logic s, input logic [7:0] f, input int slow);
    host_link_model_i.transfer(1'b0, '0, '{status: s, flags: f}, slow);
    cyc(10);
  endtask : rd

  task automatic wait_ready;
    int n;
    n = 0;
    while (data_not_ready !== 1'b0 && n < 400) begin
      cyc(1);
      n++;
    end
    if (n >= 400) begin
      errors++;
      $display("[FAIL] %0t init never ended", $time);
      close_out();
    end else begin
      cyc(3);
      check(interrupt_request_n, 0, "init irq");
      check(fully_functional, 1, "ready");
    end
  endtask : wait_ready

  task automatic test_init;
    wait_ready();
    check(flags, 8'h00, "flags reset");
    module_select_n = 1'b0;
    cyc(6);
    check(serial_enable, 1, "select on");
    module_select_n = 1'b1;
    cyc(6);
    check(serial_enable, 0, "select off");
    module_select_n = 1'b0;
    cyc(6);
    rd(1'b1, 8'h00, 2);
    check(interrupt_request_n, 1, "status read");
    $display("test init done");
  endtask : test_init

  task automatic test_flags;
    for (int i = 0; i < 8; i++) begin
      flag_condition = 8'h01 << i;
      cyc(6);
      check(flags, 8'h01 << i, "flag set");
      check(interrupt_request_n, 0, "irq set");
      flag_condition = 8'h00;
      cyc(6);
      check(flags, 8'h01 << i, "flag latched");
      rd(1'b0, ~(8'h01 << i), 0);
      check(flags, 8'h01 << i, "other read");
      rd(1'b0, 8'h01 << i, i % 2);
      check(flags, 8'h00, "flag cleared");
      check(interrupt_request_n, 1, "irq off");
    end
    $display("test flags done");
  endtask : test_flags

  task automatic test_mask;
    wr(8'h01, 1'b0);
    flag_condition = 8'h01;
    cyc(6);
    check(flags, 8'h01, "masked flag");
    check(interrupt_request_n, 1, "masked irq");
    flag_condition = 8'h00;
    wr(8'h00, 1'b0);
    check(interrupt_request_n, 0, "unmasked");
    rd(1'b0, 8'h01, 0);
    check(interrupt_request_n, 1, "mask clear");
    $display("test mask done");
  endtask : test_mask

  task automatic test_power;
    low_power_request = 1'b1;
    cyc(6);
    check(low_power_active, 1, "pin low power");
    check(fully_functional, 0, "pin ff");
    low_power_request = 1'b0;
    cyc(6);
    check(fully_functional, 1, "pin exit");
    wr(8'h00, 1'b1);
    check(low_power_active, 1, "pdown set");
    check(fully_functional, 0, "pdown ff");
    wr(8'h00, 1'b0);
    check(low_power_active, 0, "pdown clear");
    check(fully_functional, 1, "pdown exit");
    $display("test power done");
  endtask : test_power

  task automatic test_pin_reset;
    wr(8'h5a, 1'b0);
    module_reset_n = 1'b0;
    cyc(100);
    module_reset_n = 1'b1;
    cyc(6);
    check(mask, 8'h5a, "short pulse");
    module_reset_n = 1'b0;
    cyc(300);
    check(mask, 8'h00, "pin reset mask");
    check(data_not_ready, 1, "pin reset dnr");
    check(interrupt_request_n, 1, "pin reset irq");
    module_reset_n = 1'b1;
    wait_ready();
    rd(1'b1, 8'h00, 0);
    check(interrupt_request_n, 1, "reinit read");
    $display("test pin reset done");
  endtask : test_pin_reset

  initial begin
    rst = 1'b1;
    module_reset_n = 1'b1;
    module_select_n = 1'b1;
    low_power_request = 1'b0;
    flag_condition = 8'h00;
    errors = 0;
    samples_checked = 0;
    cyc(2);
    rst = 1'b0;
    check(interrupt_request_n, 1, "reset irq");
    check(data_not_ready, 1, "reset dnr");
    test_init();
    test_flags();
    test_mask();
    test_power();
    test_pin_reset();
    close_out();
  end
endmodule : tb
